/* rtl/xdata_exec_defs.vh */
// Constants for the external data move and byte multiply execution block.
`ifndef XDATA_EXEC_DEFS_VH
`define XDATA_EXEC_DEFS_VH
`define OP_WR_INDEX_HI 7'h79
`define OP_RD_INDEX_HI 7'h71
`define OP_RD_POINTER 8'he0
`define OP_WR_POINTER 8'hf0
`define OP_MULTIPLY 8'ha4
`define MOVE_CYCLES 3'h2
`define MUL_CYCLES 3'h4
`define PRODUCT_LIMIT 16'h00ff
`define ACC_RESET 8'h00
`define B_RESET 8'h00
`define PORT_LATCH_RESET 8'hff
`endif

/* rtl/xdata_move_and_multiply_exec.v */
// External data move and unsigned byte multiply execution block.
// What this block does
// - Multiply takes accumulator and B unsigned, one byte, four machine cycles.
// - Product low byte goes to accumulator, high byte goes to B.
// - Overflow set when product exceeds 255, cleared otherwise.
// - Every multiply clears the carry flag.
// - Opcode 1111001i writes accumulator to external byte at index register, two cycles.
// - Index form drives the register on low port, multiplexed with data.
// - Pointer form drives high byte on high port, low byte on low port.
// - High port latch keeps its value while pointer high byte is emitted.
`timescale 1ns/1ns
`default_nettype none
`include "xdata_exec_defs.vh"
module xdata_move_and_multiply_exec (
    input wire sys_clk_in,
    input wire reset_n_in,
    input wire issue_in,
    input wire [7:0] opcode_in,
    input wire [7:0] index_reg0_in,
    input wire [7:0] index_reg1_in,
    input wire [7:0] data_pointer_high_in,
    input wire [7:0] data_pointer_low_in,
    input wire load_acc_in,
    input wire [7:0] acc_value_in,
    input wire load_b_in,
    input wire [7:0] b_value_in,
    input wire load_port_latch_in,
    input wire [7:0] port_latch_value_in,
    input wire [7:0] low_port_bus_in,
    output reg [7:0] low_port_bus_out,
    output reg low_port_bus_oe_out,
    output reg [7:0] high_port_bus_out,
    output reg address_strobe_out,
    output reg read_strobe_n_out,
    output reg write_strobe_n_out,
    output reg [7:0] acc_out,
    output reg [7:0] b_out,
    output reg overflow_out,
    output reg carry_clear_out,
    output reg busy_out,
    output reg done_out
);
// ***********************************************************
// State and storage
// ***********************************************************
localparam ST_IDLE = 2'h0;
localparam ST_ADDR = 2'h1;
localparam ST_DATA = 2'h2;
localparam ST_MUL = 2'h3;
reg [1:0] state_reg;
reg [2:0] count_reg;
reg is_write_reg;
reg use_pointer_reg;
reg [7:0] port_latch_reg;
reg [15:0] product_reg;
wire [15:0] product_full;
wire [7:0] port_latch_next;
wire is_index_wr;
wire is_index_rd;
wire is_ptr_rd;
wire is_ptr_wr;
wire is_mul;
wire is_move;
wire [7:0] index_sel;
// ***********************************************************
// Decode and arithmetic helpers
// ***********************************************************
// Matches the upper seven opcode bits of an index register form.
function index_form;
    input [7:0] op;
    input [6:0] upper;
    begin
        index_form = (op[7:1] == upper);
    end
endfunction
// Matches one whole opcode byte.
function whole_opcode;
    input [7:0] op;
    input [7:0] code;
    begin
        whole_opcode = (op == code);
    end
endfunction
// Forms the sixteen-bit unsigned product of two bytes.
function [15:0] byte_product;
    input [7:0] left;
    input [7:0] right;
    begin
        byte_product = {8'h00, left} * {8'h00, right};
    end
endfunction
// True when a product does not fit in one byte.
function product_overflows;
    input [15:0] product;
    begin
        product_overflows = (product > `PRODUCT_LIMIT);
    end
endfunction
// ***********************************************************
// Instruction decode
// ***********************************************************
assign product_full = byte_product(acc_out, b_out);
assign port_latch_next = load_port_latch_in ? port_latch_value_in : port_latch_reg;
assign is_index_wr = index_form(opcode_in, `OP_WR_INDEX_HI);
assign is_index_rd = index_form(opcode_in, `OP_RD_INDEX_HI);
assign is_ptr_rd = whole_opcode(opcode_in, `OP_RD_POINTER);
assign is_ptr_wr = whole_opcode(opcode_in, `OP_WR_POINTER);
assign is_mul = whole_opcode(opcode_in, `OP_MULTIPLY);
assign is_move = is_index_wr | is_index_rd | is_ptr_rd | is_ptr_wr;
assign index_sel = opcode_in[0] ? index_reg1_in : index_reg0_in;
// ***********************************************************
// Sequencer
// ***********************************************************
always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        state_reg <= ST_IDLE;
        count_reg <= 3'h0;
        is_write_reg <= 1'b0;
        use_pointer_reg <= 1'b0;
        port_latch_reg <= `PORT_LATCH_RESET;
        product_reg <= 16'h0000;
        low_port_bus_out <= 8'h00;
        low_port_bus_oe_out <= 1'b0;
        high_port_bus_out <= `PORT_LATCH_RESET;
        address_strobe_out <= 1'b0;
        read_strobe_n_out <= 1'b1;
        write_strobe_n_out <= 1'b1;
        acc_out <= `ACC_RESET;
        b_out <= `B_RESET;
        overflow_out <= 1'b0;
        carry_clear_out <= 1'b0;
        busy_out <= 1'b0;
        done_out <= 1'b0;
    end else begin
        done_out <= 1'b0;
        carry_clear_out <= 1'b0;
        if (load_port_latch_in) begin
            port_latch_reg <= port_latch_value_in;
        end
        case (state_reg)
            ST_IDLE: begin
                address_strobe_out <= 1'b0;
                read_strobe_n_out <= 1'b1;
                write_strobe_n_out <= 1'b1;
                low_port_bus_oe_out <= 1'b0;
                high_port_bus_out <= port_latch_next;
                if (load_acc_in) begin
                    acc_out <= acc_value_in;
                end
                if (load_b_in) begin
                    b_out <= b_value_in;
                end
                if (issue_in && is_mul) begin
                    product_reg <= product_full;
                    // The count runs down to one, so busy stands for four cycles.
                    count_reg <= `MUL_CYCLES;
                    busy_out <= 1'b1;
                    state_reg <= ST_MUL;
                end else if (issue_in && is_move) begin
                    is_write_reg <= is_index_wr | is_ptr_wr;
                    use_pointer_reg <= is_ptr_rd | is_ptr_wr;
                    busy_out <= 1'b1;
                    address_strobe_out <= 1'b1;
                    low_port_bus_oe_out <= 1'b1;
                    if (is_ptr_rd || is_ptr_wr) begin
                        low_port_bus_out <= data_pointer_low_in;
                        high_port_bus_out <= data_pointer_high_in;
                    end else begin
                        low_port_bus_out <= index_sel;
                    end
                    state_reg <= ST_ADDR;
                end
            end
            ST_ADDR: begin
                // Second machine cycle carries the data phase.
                address_strobe_out <= 1'b0;
                if (!use_pointer_reg) begin
                    high_port_bus_out <= port_latch_next;
                end
                if (is_write_reg) begin
                    low_port_bus_out <= acc_out;
                    write_strobe_n_out <= 1'b0;
                end else begin
                    low_port_bus_oe_out <= 1'b0;
                    read_strobe_n_out <= 1'b0;
                end
                state_reg <= ST_DATA;
            end
            ST_DATA: begin
                if (!is_write_reg) begin
                    // The memory answers on this clock inside the read strobe, so no synchroniser.
                    acc_out <= low_port_bus_in;
                end
                read_strobe_n_out <= 1'b1;
                write_strobe_n_out <= 1'b1;
                low_port_bus_oe_out <= 1'b0;
                high_port_bus_out <= port_latch_next;
                use_pointer_reg <= 1'b0;
                busy_out <= 1'b0;
                done_out <= 1'b1;
                state_reg <= ST_IDLE;
            end
            ST_MUL: begin
                if (count_reg == 3'h1) begin
                    acc_out <= product_reg[7:0];
                    b_out <= product_reg[15:8];
                    overflow_out <= product_overflows(product_reg);
                    carry_clear_out <= 1'b1;
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                count_reg <= count_reg - 3'h1;
            end
            default: begin
                state_reg <= ST_IDLE;
            end
        endcase
    end
end
endmodule // xdata_move_and_multiply_exec
`default_nettype wire

/* tb/xdata_exec_props.sv */
// Checker for the external move and byte multiply block.
`timescale 1ns/1ns
`default_nettype none
module xdata_exec_props (
    input wire logic sys_clk_in, reset_n_in, issue_in, busy_out, done_out, overflow_out,
    input wire logic carry_clear_out, address_strobe_out, low_port_bus_oe_out, write_strobe_n_out,
    input wire logic [7:0] opcode_in, index_reg0_in, index_reg1_in, acc_out, b_out,
    input wire logic [7:0] data_pointer_high_in, data_pointer_low_in,
    input wire logic [7:0] low_port_bus_out, high_port_bus_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    wire logic take = issue_in && !busy_out;
    wire logic mul = take && opcode_in == 8'ha4;
    wire logic ptr = take && (opcode_in == 8'he0 || opcode_in == 8'hf0);
    wire logic idx = take && opcode_in[7:5] == 3'h7 && opcode_in[3:1] == 3'h1;
    mul_time_a: assert property (mul |=> !done_out [*4] ##1 done_out && carry_clear_out)
        else $error("multiply timing");
    mul_result_a: assert property (mul |-> ##5
        {b_out, acc_out} == $past(acc_out, 5) * $past(b_out, 5)) else $error("product");
    mul_flag_a: assert property (mul |-> ##5
        overflow_out == ($past(acc_out, 5) * $past(b_out, 5) > 16'h00ff)) else $error("overflow");
    move_time_a: assert property ((idx || ptr) |=> !done_out ##1 !done_out ##1 done_out)
        else $error("move timing");
    index_addr_a: assert property (idx |=> address_strobe_out && low_port_bus_oe_out &&
        low_port_bus_out == $past(opcode_in[0] ? index_reg1_in : index_reg0_in)) else $error("index");
    pointer_addr_a: assert property (ptr |=> {high_port_bus_out, low_port_bus_out} ==
        $past({data_pointer_high_in, data_pointer_low_in})) else $error("pointer");
    write_data_a: assert property ((idx || ptr) && opcode_in[4] |-> ##2 !write_strobe_n_out &&
        low_port_bus_oe_out && low_port_bus_out == $past(acc_out, 2)) else $error("write data");
    latch_keep_a: assert property (ptr |-> ##3
        high_port_bus_out == $past(high_port_bus_out, 3)) else $error("latch lost");
endmodule // xdata_exec_props
bind xdata_move_and_multiply_exec xdata_exec_props i_props (.*);
`default_nettype wire

/* tb/xdata_ram_model.sv */
// Behavioural external data memory on the multiplexed port buses.
`timescale 1ns/1ns
`default_nettype none
module xdata_ram_model (
    input wire logic clk_in, ale_in, oe_in, rd_n_in, wr_n_in,
    input wire logic [7:0] low_in, high_in,
    output logic [7:0] data_out
);
    logic [7:0] mem [0:65535];
    logic [15:0] addr_reg;
    logic held_reg = 1'h0;
    always @(posedge clk_in) begin
        if (ale_in) addr_reg <= {high_in, low_in};
        if (!wr_n_in) mem[addr_reg] <= low_in;
        held_reg <= !rd_n_in;
    end
    wire logic [7:0] q = mem[addr_reg];
    assign data_out = oe_in ? low_in : (!rd_n_in || held_reg) ? q : ~q;
endmodule // xdata_ram_model
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the external move and byte multiply block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic sys_clk_in = '0, reset_n_in = '0, issue_in = '0, load_acc_in = '0, load_port_latch_in = '0;
    logic [7:0] opcode_in = '0, acc_value_in = '0, b_value_in = '0, port_latch_value_in = 8'h3c;
    logic [7:0] index_reg0_in = 8'h12, index_reg1_in = 8'h34;
    logic [7:0] data_pointer_high_in = 8'hc3, data_pointer_low_in = 8'he5;
    wire logic load_b_in = load_acc_in;
    wire logic [7:0] low_port_bus_in, low_port_bus_out, high_port_bus_out, acc_out, b_out;
    wire logic low_port_bus_oe_out, address_strobe_out, read_strobe_n_out, write_strobe_n_out;
    wire logic overflow_out, carry_clear_out, busy_out, done_out;
    int n_fail = 0, checked = 0, cyc = 0, n_done = 0;
    logic [43:0] rows [10] = '{44'ha4_50_a0_00_32_1, 44'ha4_ff_ff_01_fe_1, 44'ha4_0f_11_ff_00_0,
        44'ha4_10_10_00_01_1, 44'hf2_56_00_56_00_0, 44'hf3_78_00_78_00_0, 44'hf0_9a_00_9a_00_0,
        44'he2_00_00_56_00_0, 44'he3_00_00_78_00_0, 44'he0_00_00_9a_00_0};
    xdata_move_and_multiply_exec i_dut (.*);
    xdata_ram_model i_ram (.clk_in(sys_clk_in), .ale_in(address_strobe_out),
        .oe_in(low_port_bus_oe_out), .rd_n_in(read_strobe_n_out), .wr_n_in(write_strobe_n_out),
        .low_in(low_port_bus_out), .high_in(high_port_bus_out), .data_out(low_port_bus_in));
    initial forever #25 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) n_done <= n_done + done_out;
    always @(posedge sys_clk_in) if (++cyc == 3000) tally_and_finish(1);
    task automatic chk(input logic [7:0] got, exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [43:0] r);
        int n;
        @(posedge sys_clk_in);
        load_acc_in <= 1'h1;
        acc_value_in <= r[35:28];
        b_value_in <= r[27:20];
        @(posedge sys_clk_in);
        load_acc_in <= 1'h0;
        issue_in <= 1'h1;
        opcode_in <= r[43:36];
        @(posedge sys_clk_in);
        issue_in <= 1'h0;
        for (n = 0; n < 8 && done_out !== 1'h1; n++) @(negedge sys_clk_in);
        chk({7'h0, done_out}, 8'h01);
        chk(n[7:0], (r[43:36] == 8'ha4) ? 8'h05 : 8'h03);
        chk(acc_out, r[19:12]);
        if (r[43:36] == 8'ha4) begin
            chk(b_out, r[11:4]);
            chk({7'h0, overflow_out}, {7'h0, r[0]});
            chk({7'h0, carry_clear_out}, 8'h01);
        end
        $display("test %h done", r[43:36]);
    endtask
    task automatic tally_and_finish(input int extra);
        n_fail += extra;
        $display("checked %0d failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk_in);
        chk(high_port_bus_out, 8'hff);
        chk({5'h0, busy_out, read_strobe_n_out, write_strobe_n_out}, 8'h03);
        $display("reset test done");
        reset_n_in <= 1'h1;
        load_port_latch_in <= 1'h1;
        @(posedge sys_clk_in);
        load_port_latch_in <= 1'h0;
        foreach (rows[k]) run(rows[k]);
        @(posedge sys_clk_in);
        issue_in <= 1'h1;
        opcode_in <= 8'ha4;
        @(posedge sys_clk_in);
        opcode_in <= 8'hf2;
        repeat (2) @(posedge sys_clk_in);
        opcode_in <= 8'h00;
        repeat (8) @(posedge sys_clk_in);
        issue_in <= 1'h0;
        chk(n_done[7:0], 8'h0b);
        $display("refusal test done");
        tally_and_finish(0);
    end
endmodule // tb_top
`default_nettype wire
